// *** clb_pkg.sv ***
// Package with constants, encodings and carrier types for the local bus interface.
`default_nettype none
package clb_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int VEC_W = 8;
	localparam int IO_HI_LSB = 16;
	localparam int IO_HI_MSB = 23;
	localparam logic [7:0] NMI_VECTOR = 8'h02;
	localparam int NMI_MIN_CLK = 4;
	localparam int MASKABLE_IRQ_LEAD_PCYC = 2;
	localparam int INTA_CYCLES = 2;
	localparam logic [1:0] ST_INTA = 2'h0;
	localparam logic [1:0] ST_HALT = 2'h0;
	localparam logic [1:0] ST_READ = 2'h1;
	localparam logic [1:0] ST_WRITE = 2'h2;
	localparam logic [1:0] ST_IDLE = 2'h3;

	typedef enum logic [2:0]
	{
		CLB_MEM_RD,
		CLB_MEM_WR,
		CLB_IO_RD,
		CLB_IO_WR,
		CLB_FETCH,
		CLB_HALT,
		CLB_SHUTDOWN
	} clb_kind_e;

	typedef struct packed
	{
		clb_kind_e           kind;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic                word;
		logic                lock;
	} clb_req_s;

	typedef struct packed
	{
		logic [DATA_W-1:0]   rdata;
		logic                is_vector;
	} clb_rsp_s;

	typedef struct packed
	{
		logic [1:0]          status_n;
		logic                mem_io;
		logic                code_intack_select;
		logic                lock_n;
		logic                upper_byte_enable_n;
		logic [ADDR_W-1:0]   addr;
	} clb_pins_s;
endpackage
`default_nettype wire

// *** clb_bus_if.sv ***
// Local bus master interface: cycle sequencing, hold handover and interrupt intake.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Processor clock is system clock halved.
// - Reset release realigns the divider phase.
// - Sample data on reads, drive on writes.
// - Address out; upper eight bits low for I/O.
// - Upper enable and A0 encode byte lanes.
// - Either status low marks the status state.
// - Code-low status encodings: acknowledge, halt, memory data.
// - Code-high encodings: I/O and fetch; 11 idle.
// - Memory select high for memory and halt.
// - Lock asserted on prefix, swap, acknowledge, tables.
// - Cycle ends only when ready goes low.
// - Ready ignored during hold acknowledge.
// - Float drivers first, then acknowledge hold.
// - Release bus when hold request drops.
// - Hold signals active high, request asynchronous.
// - All bus outputs float while holding.
// - Maskable request level, gated by enable flag.
// - Two acknowledge cycles fetch eight-bit vector.
// - Sample each processor cycle, two-cycle lead.
// - Non-maskable uses vector two, no acknowledge.
// - Non-maskable edge needs four low, four high.
module clb_bus_if
(
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic               req_valid,
	output logic                    req_ready,
	input  wire clb_pkg::clb_req_s  req,
	output logic                    rsp_valid,
	input  wire logic               rsp_ready,
	output clb_pkg::clb_rsp_s       rsp,
	input  wire logic               irq_enable,
	input  wire logic               instr_end_soon,
	output logic                    irq_take,
	output logic                    nmi_take,
	output logic [7:0]              irq_vector,
	output clb_pkg::clb_pins_s      pins,
	output logic                    pins_oe,
	input  wire logic [15:0]        data_in,
	output logic [15:0]             data_out,
	output logic                    data_oe,
	input  wire logic               ready_n,
	input  wire logic               hold_req,
	output logic                    bus_grant_ack,
	input  wire logic               maskable_irq,
	input  wire logic               nmi_req
);
	import clb_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_STATUS, S_CMD, S_FLOAT, S_HOLD} clb_state_e;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers.
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end
		else
		begin
			sync1_q <= {nmi_req, maskable_irq, hold_req};
			sync2_q <= sync1_q;
		end
	end
	logic hold_s, maskable_irq_s, nmi_s;
	assign hold_s = sync2_q[0];
	assign maskable_irq_s = sync2_q[1];
	assign nmi_s = sync2_q[2];

	////////////////////////////////////////////////////////////////////////
	// Processor clock phase; reset release restarts it at phase one.
	logic phase_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			phase_q <= 1'b0;
		else
			phase_q <= ~phase_q;
	end
	logic pcyc;
	assign pcyc = phase_q;

	////////////////////////////////////////////////////////////////////////
	// Two-entry request buffer.
	clb_req_s buf_q [2];
	logic [1:0] cnt_q;
	logic rd_q, wr_q;
	logic pop;
	assign req_ready = (cnt_q != 2'h2);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 2'h0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end
		else
		begin
			if (req_valid && req_ready)
			begin
				buf_q[wr_q] <= req;
				wr_q <= ~wr_q;
			end
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, req_valid && req_ready} - {1'b0, pop};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle status encoding.
	function automatic logic [3:0] enc_status(input clb_kind_e k, input logic inta);
		// Returns {code_intack_select, mem_io, status1_n, status0_n}.
		if (inta)
			return {1'b0, 1'b0, ST_INTA};
		case (k)
			CLB_MEM_RD:   return {1'b0, 1'b1, ST_READ};
			CLB_MEM_WR:   return {1'b0, 1'b1, ST_WRITE};
			CLB_HALT,
			CLB_SHUTDOWN: return {1'b0, 1'b1, ST_HALT};
			CLB_IO_RD:    return {1'b1, 1'b0, ST_READ};
			CLB_IO_WR:    return {1'b1, 1'b0, ST_WRITE};
			CLB_FETCH:    return {1'b1, 1'b1, ST_READ};
			default:      return {1'b0, 1'b0, ST_IDLE};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Interrupt intake.
	logic maskable_irq_seen_q, maskable_irq_lead_q, nmi_pend_q;
	logic [2:0] nmi_lo_q, nmi_hi_q;
	logic inta_run_q, inta_idx_q;
	logic rsp_full;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			maskable_irq_seen_q <= 1'b0;
			maskable_irq_lead_q <= 1'b0;
			nmi_pend_q <= 1'b0;
			nmi_lo_q <= 3'h0;
			nmi_hi_q <= 3'h0;
		end
		else
		begin
			if (pcyc)
			begin
				maskable_irq_seen_q <= maskable_irq_s && irq_enable;
				maskable_irq_lead_q <= maskable_irq_seen_q && maskable_irq_s && irq_enable;
			end
			if (nmi_s)
				nmi_hi_q <= (nmi_hi_q == 3'(NMI_MIN_CLK)) ? nmi_hi_q : nmi_hi_q + 3'h1;
			else
				nmi_hi_q <= 3'h0;
			if (!nmi_s)
				nmi_lo_q <= (nmi_lo_q == 3'(NMI_MIN_CLK)) ? nmi_lo_q : nmi_lo_q + 3'h1;
			else if (nmi_hi_q == 3'(NMI_MIN_CLK - 1) && nmi_pend_q == 1'b0)
				nmi_lo_q <= 3'h0;
			if (nmi_s && nmi_hi_q == 3'(NMI_MIN_CLK - 1) && nmi_lo_q == 3'(NMI_MIN_CLK))
				nmi_pend_q <= 1'b1;
			else if (nmi_take)
				nmi_pend_q <= 1'b0;
		end
	end
	assign nmi_take = nmi_pend_q && instr_end_soon && !inta_run_q;
	logic irq_start;
	assign irq_start = maskable_irq_lead_q && instr_end_soon && !inta_run_q && !nmi_pend_q;
	assign irq_take = irq_start;

	////////////////////////////////////////////////////////////////////////
	// Bus cycle sequencer and hold handover.
	clb_state_e state_q;
	clb_req_s cur_q;
	logic [7:0] vec_q;
	clb_rsp_s rsp_q;
	logic rsp_v_q;
	logic cur_inta_q;
	assign rsp_full = rsp_v_q && !rsp_ready;
	assign pop = (state_q == S_IDLE) && pcyc && !hold_s && !inta_run_q && !irq_start && !rsp_full && cnt_q != 2'h0;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= S_IDLE;
			cur_q <= '0;
			cur_inta_q <= 1'b0;
			inta_run_q <= 1'b0;
			inta_idx_q <= 1'b0;
			vec_q <= 8'h00;
			rsp_q <= '0;
			rsp_v_q <= 1'b0;
		end
		else
		begin
			if (rsp_v_q && rsp_ready)
				rsp_v_q <= 1'b0;
			if (irq_start)
			begin
				inta_run_q <= 1'b1;
				inta_idx_q <= 1'b0;
			end
			case (state_q)
				S_IDLE:
				begin
					if (hold_s && pcyc)
						state_q <= S_FLOAT;
					else if (pcyc && inta_run_q && !rsp_full)
					begin
						cur_inta_q <= 1'b1;
						cur_q.lock <= 1'b1;
						cur_q.word <= 1'b0;
						state_q <= S_STATUS;
					end
					else if (pop)
					begin
						cur_q <= buf_q[rd_q];
						cur_inta_q <= 1'b0;
						state_q <= S_STATUS;
					end
				end
				S_STATUS:
					if (pcyc)
						state_q <= S_CMD;
				S_CMD:
					if (!ready_n && pcyc)
					begin
						state_q <= S_IDLE;
						if (cur_inta_q)
						begin
							inta_idx_q <= ~inta_idx_q;
							if (inta_idx_q)
							begin
								inta_run_q <= 1'b0;
								vec_q <= data_in[7:0];
								rsp_q <= '{rdata: {8'h00, data_in[7:0]}, is_vector: 1'b1};
								rsp_v_q <= 1'b1;
							end
						end
						else
						begin
							rsp_q <= '{rdata: data_in, is_vector: 1'b0};
							rsp_v_q <= 1'b1;
						end
					end
				S_FLOAT:
					state_q <= S_HOLD;
				S_HOLD:
					if (!hold_s)
						state_q <= S_IDLE;
				default:
					state_q <= S_IDLE;
			endcase
		end
	end
	assign rsp_valid = rsp_v_q;
	assign rsp = rsp_q;

	////////////////////////////////////////////////////////////////////////
	// Pin drive.
	logic [3:0] enc;
	logic is_io, is_wr;
	assign enc = enc_status(cur_q.kind, cur_inta_q);
	assign is_io = !cur_inta_q && (cur_q.kind == CLB_IO_RD || cur_q.kind == CLB_IO_WR);
	assign is_wr = !cur_inta_q && (cur_q.kind == CLB_MEM_WR || cur_q.kind == CLB_IO_WR);
	logic active;
	assign active = (state_q == S_STATUS) || (state_q == S_CMD);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pins <= '{status_n: ST_IDLE, mem_io: 1'b0, code_intack_select: 1'b0, lock_n: 1'b1,
			          upper_byte_enable_n: 1'b1, addr: {ADDR_W{1'b1}}};
			pins_oe <= 1'b1;
			data_out <= 16'h0000;
			data_oe <= 1'b0;
			bus_grant_ack <= 1'b0;
			irq_vector <= 8'h00;
		end
		else
		begin
			pins.status_n <= (state_q == S_STATUS) ? enc[1:0] : ST_IDLE;
			pins.code_intack_select <= enc[3];
			pins.mem_io <= enc[2];
			pins.lock_n <= !(active && cur_q.lock);
			pins.upper_byte_enable_n <= !(cur_q.word || cur_q.addr[0]);
			pins.addr <= cur_q.addr;
			if (is_io)
				pins.addr[IO_HI_MSB:IO_HI_LSB] <= 8'h00;
			if (cur_q.kind == CLB_HALT && !cur_inta_q)
				pins.addr[1] <= 1'b1;
			if (cur_q.kind == CLB_SHUTDOWN && !cur_inta_q)
				pins.addr[1] <= 1'b0;
			pins_oe <= !(state_q == S_FLOAT || state_q == S_HOLD);
			data_out <= cur_q.wdata;
			data_oe <= (state_q == S_CMD) && is_wr;
			bus_grant_ack <= (state_q == S_HOLD) && hold_s;
			if (nmi_take)
				irq_vector <= NMI_VECTOR;
			else if (rsp_v_q && rsp_q.is_vector)
				irq_vector <= vec_q;
		end
	end
endmodule
`default_nettype wire

// *** clb_bus_if_assertions.sv ***
// Checker for the local bus pins, hold handover and interrupt vector.
`timescale 1ns/1ps
`default_nettype none
module clb_bus_if_assertions
(
	input wire logic               clk,
	input wire logic               arst_n,
	input wire clb_pkg::clb_pins_s pins,
	input wire logic               pins_oe,
	input wire logic               data_oe,
	input wire logic               ready_n,
	input wire logic               bus_grant_ack,
	input wire logic               rsp_valid,
	input wire logic               nmi_take,
	input wire logic [7:0]         irq_vector
);
	import clb_pkg::*;
	wire ts = pins_oe && pins.status_n != 2'h3;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////
	property p_io_hi;
		ts && pins.code_intack_select && !pins.mem_io |-> pins.addr[23:16] == 8'h00;
	endproperty
	a_io_hi: assert property (p_io_hi) else $error("io address high bits set");
	property p_code;
		ts && pins.code_intack_select |-> pins.status_n != 2'h0 && (!pins.mem_io || pins.status_n == 2'h1);
	endproperty
	a_code: assert property (p_code) else $error("reserved code high status");
	property p_ack;
		ts && !pins.code_intack_select && !pins.mem_io |-> pins.status_n == 2'h0 && !pins.lock_n;
	endproperty
	a_ack: assert property (p_ack) else $error("bad acknowledge status or lock");
	property p_lane;
		ts |-> !(pins.upper_byte_enable_n && pins.addr[0]);
	endproperty
	a_lane: assert property (p_lane) else $error("reserved byte lane code");
	property p_ts;
		ts && !$past(ts) |=> ts ##1 !ts;
	endproperty
	a_ts: assert property (p_ts) else $error("status state length wrong");
	property p_float;
		$rose(bus_grant_ack) |-> !$past(pins_oe);
	endproperty
	a_float: assert property (p_float) else $error("grant before drivers off");
	property p_off;
		bus_grant_ack |-> !pins_oe && !data_oe;
	endproperty
	a_off: assert property (p_off) else $error("driving during hold");
	property p_end;
		$rose(rsp_valid) |-> !$past(ready_n) || !$past(ready_n, 2);
	endproperty
	a_end: assert property (p_end) else $error("cycle ended without ready");
	property p_nmi;
		nmi_take |=> irq_vector == NMI_VECTOR;
	endproperty
	a_nmi: assert property (p_nmi) else $error("wrong nonmaskable vector");
endmodule
bind clb_bus_if clb_bus_if_assertions i_chk
(
	.clk(clk), .arst_n(arst_n), .pins(pins), .pins_oe(pins_oe), .data_oe(data_oe),
	.ready_n(ready_n), .bus_grant_ack(bus_grant_ack), .rsp_valid(rsp_valid),
	.nmi_take(nmi_take), .irq_vector(irq_vector)
);
`default_nettype wire

// *** clb_mem_model.sv ***
// Bus controller and memory model on the far side of the local bus.
`timescale 1ns/1ps
`default_nettype none
module clb_mem_model
(
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire clb_pkg::clb_pins_s pins,
	input  wire logic               pins_oe,
	input  wire logic [15:0]        data_out,
	input  wire logic               data_oe,
	input  wire logic [3:0]         wait_cycles,
	input  wire logic [7:0]         vec,
	output logic [15:0]             data_in,
	output logic                    ready_n
);
	import clb_pkg::*;
	logic [15:0] mem [16];
	logic [15:0] last;
	logic [3:0]  cnt;
	logic [3:0]  a;
	logic        cmd;
	logic        ack;
	assign ready_n = !(cmd && cnt >= wait_cycles);
	assign data_in = data_oe ? data_out : cmd ? (ack ? {8'h00, vec} : mem[a]) : ~last;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmd <= 1'b0;
			cnt <= 4'h0;
			last <= 16'h0000;
		end
		else
		begin
			last <= data_in;
			if (pins_oe && pins.status_n != 2'h3)
			begin
				cmd <= 1'b1;
				cnt <= 4'h0;
				a <= pins.addr[4:1] ^ pins.addr[23:20];
				ack <= !pins.code_intack_select && !pins.mem_io;
			end
			else if (cmd && cnt != 4'hf)
				cnt <= cnt + 4'h1;
			if (cmd && !ready_n && data_oe)
				mem[a] <= data_out;
		end
	end
endmodule
`default_nettype wire

// *** clb_tb.sv ***
// Self-checking testbench for the local bus interface.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import clb_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, rsp_ready = 1'b0, irq_enable = 1'b0;
	logic instr_end_soon = 1'b0, hold_req = 1'b0, maskable_irq = 1'b0, nmi_req = 1'b0, ack_q = 1'b0;
	logic req_ready, rsp_valid, irq_take, nmi_take, pins_oe, data_oe, ready_n, bus_grant_ack;
	logic [3:0]  wait_cycles = 4'h0;
	logic [7:0]  irq_vector;
	logic [15:0] data_in, data_out;
	clb_req_s    req = '0;
	clb_rsp_s    rsp, got;
	clb_pins_s   pins;
	int          miscompares = 0, total_checks = 0, ack_cnt = 0, irq_cnt = 0, lat;
	wire ack_now = pins_oe && pins.status_n == 2'h0 && !pins.mem_io && !pins.code_intack_select;
	wire [3:0] flags = {nmi_take, irq_take, bus_grant_ack, req_ready};
	localparam int W_RDY = 0, W_GNT = 1, W_IRQ = 2, W_NMI = 3;
	always #12.5 clk = ~clk;
	clb_bus_if i_dut
	(
		.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .irq_enable(irq_enable),
		.instr_end_soon(instr_end_soon), .irq_take(irq_take), .nmi_take(nmi_take),
		.irq_vector(irq_vector), .pins(pins), .pins_oe(pins_oe), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .ready_n(ready_n), .hold_req(hold_req),
		.bus_grant_ack(bus_grant_ack), .maskable_irq(maskable_irq), .nmi_req(nmi_req)
	);
	clb_mem_model i_mem
	(
		.clk(clk), .arst_n(arst_n), .pins(pins), .pins_oe(pins_oe), .data_out(data_out),
		.data_oe(data_oe), .wait_cycles(wait_cycles), .vec(8'h5b), .data_in(data_in), .ready_n(ready_n)
	);
	always @(posedge clk)
	begin
		ack_q <= ack_now;
		if (ack_now && !ack_q)
			ack_cnt++;
		if (irq_take === 1'b1)
			irq_cnt++;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_sig(input int i, input logic v);
		int n;
		n = 0;
		while (flags[i] !== v && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		check(16'(flags[i] === v), 16'h1);
	endtask
	task automatic get_rsp;
		lat = 0;
		while (rsp_valid !== 1'b1 && lat < 400)
		begin
			@(posedge clk);
			lat++;
		end
		got = rsp;
		rsp_ready <= 1'b1;
		@(posedge clk);
		rsp_ready <= 1'b0;
		check(16'(lat < 400), 16'h1);
	endtask
	task automatic xfer(input clb_kind_e k, input logic [23:0] a, input logic [15:0] w);
		req <= '{k, a, w, ~a[0], 1'b0};
		req_valid <= 1'b1;
		@(posedge clk);
		wait_sig(W_RDY, 1'b1);
		req_valid <= 1'b0;
		get_rsp;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_rw;
		xfer(CLB_MEM_WR, 24'h000104, 16'ha5c3);
		xfer(CLB_MEM_RD, 24'h000104, 16'h0000);
		check(got.rdata, 16'ha5c3);
		xfer(CLB_FETCH, 24'h000105, 16'h0000);
		check(got.rdata, 16'ha5c3);
		xfer(CLB_IO_WR, 24'hff001a, 16'h3c5a);
		xfer(CLB_IO_RD, 24'hff001a, 16'h0000);
		check(got.rdata, 16'h3c5a);
		xfer(CLB_MEM_RD, 24'h00001a, 16'h0000);
		check(got.rdata, 16'h3c5a);
		xfer(CLB_HALT, 24'h000000, 16'h0000);
		xfer(CLB_SHUTDOWN, 24'h000002, 16'h0000);
		$display("test rw done");
	endtask
	task automatic t_wait;
		int l0;
		xfer(CLB_MEM_RD, 24'h000104, 16'h0000);
		l0 = lat;
		wait_cycles <= 4'h6;
		xfer(CLB_MEM_RD, 24'h000104, 16'h0000);
		wait_cycles <= 4'h0;
		check(16'(lat >= l0 + 4), 16'h1);
		$display("test wait done");
	endtask
	task automatic t_hold;
		hold_req <= 1'b1;
		wait_sig(W_GNT, 1'b1);
		repeat (8) @(posedge clk);
		check({14'h0, pins_oe, data_oe}, 16'h0);
		check({15'h0, bus_grant_ack}, 16'h1);
		hold_req <= 1'b0;
		wait_sig(W_GNT, 1'b0);
		@(posedge clk);
		check({15'h0, pins_oe}, 16'h1);
		xfer(CLB_MEM_RD, 24'h000104, 16'h0000);
		check(got.rdata, 16'ha5c3);
		$display("test hold done");
	endtask
	task automatic t_irq;
		maskable_irq <= 1'b1;
		instr_end_soon <= 1'b1;
		repeat (12) @(posedge clk);
		check(16'(irq_cnt), 16'h0);
		irq_enable <= 1'b1;
		wait_sig(W_IRQ, 1'b1);
		instr_end_soon <= 1'b0;
		irq_enable <= 1'b0;
		get_rsp;
		maskable_irq <= 1'b0;
		check({15'h0, got.is_vector}, 16'h1);
		check({8'h0, irq_vector}, 16'h005b);
		check(16'(ack_cnt), 16'h2);
		$display("test irq done");
	endtask
	task automatic t_nmi;
		int c0;
		c0 = ack_cnt;
		nmi_req <= 1'b1;
		instr_end_soon <= 1'b1;
		wait_sig(W_NMI, 1'b1);
		instr_end_soon <= 1'b0;
		repeat (6) @(posedge clk);
		nmi_req <= 1'b0;
		check({8'h0, irq_vector}, {8'h0, NMI_VECTOR});
		check(16'(ack_cnt - c0), 16'h0);
		$display("test nmi done");
	endtask
	task automatic t_reset;
		int n;
		for (int k = 3; k < 5; k++)
		begin
			arst_n <= 1'b0;
			repeat (k) @(posedge clk);
			arst_n <= 1'b1;
			@(posedge clk);
			req <= '{CLB_MEM_RD, 24'h000104, 16'h0000, 1'b1, 1'b0};
			req_valid <= 1'b1;
			@(posedge clk);
			req_valid <= 1'b0;
			n = 0;
			while (pins.status_n === 2'h3 && n < 10)
			begin
				@(posedge clk);
				n++;
			end
			check(16'(n), 16'h4);
			get_rsp;
			check(got.rdata, 16'ha5c3);
		end
		$display("test reset done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict;
	end
	initial
	begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_rw;
		t_wait;
		t_hold;
		t_irq;
		t_nmi;
		t_reset;
		print_verdict;
	end
endmodule
`default_nettype wire
